// >>> sim/fpc_master_model.sv
// Master station model: owns the remote write words and the control bits.
// Assumes the bench calls its tasks and keeps sys_clk running.
`timescale 1ns/1ps
`default_nettype none

module fpc_master_model (
	// Clock
	input wire logic sys_clk,
	// Panel side
	input wire fpc_pkg::fpc_word_t status_word,
	output var fpc_pkg::fpc_word_t [15:0] cmd_write_word_base,
	output var fpc_pkg::fpc_word_t ctrl_word
);
	import fpc_pkg::*;

	initial begin
		cmd_write_word_base = '0;
		ctrl_word = '0;
	end

	// Words settle one cycle before the request so the panel never decodes a half-loaded set
	task automatic issue(input logic [15:0][15:0] w, input fpc_word_t more);
		@(posedge sys_clk);
		ctrl_word <= '0;
		cmd_write_word_base <= w;
		@(posedge sys_clk);
		ctrl_word <= 16'h0001;
		do @(posedge sys_clk); while (!status_word[0] && !status_word[10]);
		ctrl_word <= 16'h0001 | more;
	endtask

	task automatic set_word(input int i, input fpc_word_t v);
		@(posedge sys_clk);
		cmd_write_word_base[i] <= v;
	endtask

	// Raw control word, used for initial setting and error reset requests
	task automatic drive(input fpc_word_t v);
		@(posedge sys_clk);
		ctrl_word <= v;
	endtask
endmodule

`default_nettype wire

// >>> sim/test_fieldbus_panel_command_map.sv
// Self-checking bench for the panel command map.
// Assumes fpc_pkg and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_fieldbus_panel_command_map;
	import fpc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	fpc_axi_req_t axi_req = '0;
	fpc_axi_rsp_t axi_rsp;
	fpc_word_t [15:0] cmd_w;
	fpc_word_t ctrl_word;
	fpc_word_t [4:0] ry_user;
	fpc_word_t status_word;
	fpc_word_t [4:0] rx_user;
	fpc_word_t [15:0] reply;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [1:0] resp;

	always #20 sys_clk = ~sys_clk;

	fpc_panel_cmd uut (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
		.cmd_write_word_base(cmd_w), .ctrl_word(ctrl_word), .ry_user(ry_user),
		.status_word(status_word), .rx_user(rx_user), .reply_read_word_base(reply));
	fpc_master_model mst (.sys_clk(sys_clk), .status_word(status_word),
		.cmd_write_word_base(cmd_w), .ctrl_word(ctrl_word));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// A hang anywhere ends here rather than in a silent simulator stall
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			close_out;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic axw(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge sys_clk);
		axi_req.awaddr <= a;
		axi_req.awvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge sys_clk);
			if (axi_req.awvalid && axi_rsp.awready) begin
				aw_ok = 1'b1;
				axi_req.awvalid <= 1'b0;
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				w_ok = 1'b1;
				axi_req.wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (axi_rsp.bvalid !== 1'b1);
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask

	task automatic axr(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		do @(posedge sys_clk); while (axi_rsp.arready !== 1'b1);
		axi_req.arvalid <= 1'b0;
		do @(posedge sys_clk); while (axi_rsp.rvalid !== 1'b1);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask

	task automatic mw(input logic [11:0] i, input fpc_word_t v);
		axw({i, 2'b00}, {16'h0000, v}, resp);
	endtask

	// Polls because periodic and mirror updates land a few cycles after their cause
	task automatic expect_mem(input logic [11:0] i, input fpc_word_t v);
		for (int k = 0; k < 16; k++) begin
			axr({i, 2'b00}, rd, resp);
			if (rd === {16'h0000, v}) break;
		end
		chk(rd, {16'h0000, v});
	endtask

	function automatic logic [15:0][15:0] mkw(input logic [7:0] c, input logic [7:0] n,
		input fpc_word_t ad);
		logic [15:0][15:0] w;
		for (int i = 1; i < 16; i++) w[i] = ad;
		w[0] = {c, n};
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		settle(2);
		chk(status_word, 32'h0800);
		axr(14'h2000, rd, resp);
		chk(rd, 32'h0009_1814);
		axr(14'h2004, rd, resp);
		chk(rd, 32'h0008_0800);
	endtask

	task automatic t_bus;
		mw(12'd100, 16'hbeef);
		expect_mem(12'd100, 16'hbeef);
		axr(14'h2008, rd, resp);
		chk(resp, 2'h2);
		chk(rd, 32'h0);
		axw(14'h1fc0, 32'h1, resp);
		chk(resp, 2'h2);
		axw(14'h2000, 32'h000f_180a, resp);
		axr(14'h2000, rd, resp);
		chk(rd, 32'h000f_1814);
		settle(2);
		chk(status_word, 32'h08a0);
		axw(14'h2000, 32'h0009_1814, resp);
	endtask

	task automatic t_link;
		for (int i = 0; i < 5; i++) begin
			mw(12'(20 + i), 16'h0a00 + 16'(i));
			settle(2);
			chk(rx_user[i], 16'h0a00 + 16'(i));
			expect_mem(12'(30 + i), 16'h0b00 + 16'(i));
		end
		mw(12'd40, 16'h5a5a);
		settle(2);
		chk(reply[0], 32'h5a5a);
		mst.set_word(0, 16'h6789);
		expect_mem(12'd56, 16'h6789);
	endtask

	// One refused command, then the error reset handshake
	task automatic expect_err(input logic [7:0] c, input logic [7:0] n, input fpc_word_t ad);
		mst.issue(mkw(c, n, ad), 16'h0000);
		settle(1);
		chk(status_word[10:0], 11'h400);
		mst.drive(16'h0400);
		mst.drive(16'h0000);
		settle(2);
		chk(status_word[10], 1'b0);
	endtask

	task automatic expect_ok(input logic [7:0] c, input logic [7:0] n, input fpc_word_t ad);
		mst.issue(mkw(c, n, ad), 16'h0000);
		settle(1);
		chk(status_word[10:0], 11'h001);
	endtask

	task automatic t_errors;
		logic [7:0] bc [6] = '{8'h06, 8'h08, 8'h06, 8'h01, 8'h06, 8'h08};
		logic [7:0] bn [6] = '{8'd11, 8'd6, 8'd0, 8'd3, 8'd1, 8'd1};
		fpc_word_t ba [6] = '{16'd0, 16'd0, 16'd0, 16'd0, 16'd2032, 16'd2032};
		for (int i = 0; i < 6; i++) begin
			mst.issue(mkw(bc[i], bn[i], ba[i]), 16'h0000);
			settle(1);
			chk(status_word[10:0], 11'h400);
			mst.drive(16'h0400);
			mst.drive(16'h0000);
			settle(2);
			chk(status_word[10], 1'b0);
		end
		mst.issue(mkw(8'h06, 8'd10, 16'd2031), 16'h0000);
		settle(1);
		chk(status_word[10:0], 11'h001);
		mst.issue(mkw(8'h08, 8'd5, 16'd5), 16'h0000);
		settle(1);
		chk(status_word[10:0], 11'h001);
		// Two occupied nodes: limits 6 and 3
		axw(14'h2000, 32'h0009_1014, resp);
		expect_err(8'h06, 8'd7, 16'd0);
		expect_err(8'h08, 8'd4, 16'd0);
		expect_ok(8'h06, 8'd6, 16'd2031);
		expect_ok(8'h08, 8'd3, 16'd5);
		// Four occupied nodes: limits 14 and 7
		axw(14'h2000, 32'h0009_2014, resp);
		expect_ok(8'h06, 8'd14, 16'd2031);
		expect_ok(8'h08, 8'd7, 16'd5);
		expect_err(8'h06, 8'd15, 16'd0);
		expect_err(8'h08, 8'd8, 16'd0);
		axw(14'h2000, 32'h0009_1814, resp);
	endtask

	task automatic t_periodic;
		logic [15:0][15:0] w;
		w = mkw(8'h08, 8'd3, 16'd0);
		w[2] = 16'd1100;
		w[3] = 16'd2031;
		mw(12'd1100, 16'hffff);
		mst.issue(w, 16'h0004);
		expect_mem(12'd0, 16'h0803);
		expect_mem(12'd1100, 16'h0000);
		expect_mem(12'd2031, 16'h044c);
		mst.set_word(1, 16'h1111);
		expect_mem(12'd1100, 16'h1111);
		mst.set_word(0, 16'h1234);
		expect_mem(12'd0, 16'h1234);
	endtask

	task automatic t_monitor;
		logic [15:0][15:0] w;
		mst.drive(16'h0200);
		settle(2);
		chk(status_word[9], 1'b1);
		mst.drive(16'h0000);
		settle(2);
		chk(status_word[9], 1'b0);
		mst.issue(mkw(8'h01, 8'h01, 16'd0), 16'h0000);
		axr(14'h2004, rd, resp);
		chk(rd[19:17], 3'b011);
		mw(12'd2031, 16'h1357);
		w = mkw(8'h06, 8'd2, 16'd100);
		w[2] = 16'd2031;
		mst.issue(w, 16'h0002);
		for (int i = 0; i < 32 && reply[1] !== 16'h1357; i++) @(posedge sys_clk);
		#1;
		chk({reply[1], reply[0]}, 32'h1357_beef);
		mst.issue(mkw(8'h01, 8'h02, 16'd0), 16'h0000);
		axr(14'h2004, rd, resp);
		chk(rd[19:17], 3'b101);
	endtask

	initial begin
		for (int i = 0; i < 5; i++) ry_user[i] = 16'h0b00 + 16'(i);
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_bus;
		t_link;
		t_errors;
		t_periodic;
		t_monitor;
		close_out;
	end
endmodule

`default_nettype wire

// >>> verilog/fpc_defines.svh
// Constants of the panel command map: offsets, bit positions, limits, reset values.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

// ----------------------------------------------------------------
// Command codes and modes
// ----------------------------------------------------------------
`define FPC_CODE_INIT 8'h01
`define FPC_CODE_MON 8'h06
`define FPC_CODE_PER 8'h08
`define FPC_INIT_CMDMON 8'h01
`define FPC_INIT_ORDMON 8'h02
`define FPC_ADDR_MAX 16'h07ef
`define FPC_MEM_WORDS 2032
// ----------------------------------------------------------------
// Count limits for four, three and two occupied nodes
// ----------------------------------------------------------------
`define FPC_MON_LIM4 8'h0e
`define FPC_MON_LIM3 8'h0a
`define FPC_MON_LIM2 8'h06
`define FPC_PER_LIM4 8'h07
`define FPC_PER_LIM3 8'h05
`define FPC_PER_LIM2 8'h03
// ----------------------------------------------------------------
// Link area layout, offsets from start address a
// ----------------------------------------------------------------
`define FPC_LINK_MIN 11'h014
`define FPC_LINK_LEN 11'h034
`define FPC_OFF_RX 11'h000
`define FPC_OFF_STAT 11'h005
`define FPC_OFF_RY 11'h00a
`define FPC_OFF_CTRL 11'h00f
`define FPC_OFF_RWR 11'h014
`define FPC_OFF_RWW 11'h024
`define FPC_USER_WORDS 11'h005
`define FPC_RW_WORDS 11'h00c
// ----------------------------------------------------------------
// Status word (panel to master) and control word (master to panel)
// ----------------------------------------------------------------
`define FPC_ST_DISP 0
`define FPC_ST_TOUCH 5
`define FPC_ST_TAG 7
`define FPC_ST_INIT 9
`define FPC_ST_ERR 10
`define FPC_ST_RDY 11
`define FPC_CT_DISP 0
`define FPC_CT_MON 1
`define FPC_CT_PER 2
`define FPC_CT_INIT 9
`define FPC_CT_ERST 10
// ----------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------
`define FPC_MEM_END 14'h2000
`define FPC_REG_CTRL 14'h2000
`define FPC_REG_STAT 14'h2004
`define FPC_CTRL_RST 32'h0009_1814
`define FPC_RESP_OKAY 2'h0
`define FPC_RESP_SLVERR 2'h2

`endif

// >>> verilog/fpc_panel_cmd.sv
// Panel command interpreter and memory map behind a fieldbus remote station.
// Assumes the fieldbus front end presents remote words and bits synchronous to sys_clk,
// and software reaches panel memory and configuration over AXI4-Lite.
//
// How it works
// - Monitor command: code 6, count within node limit
// - Monitor addresses follow, each 0 to 2031
// - Periodic write: code 8, count within node limit
// - Periodic addresses follow, each 0 to 2031
// - Registered periodic targets rewritten on each new value
// - Link start address never below 20
// - System area at memory bottom, fixed meanings
// - User input words at link a to a+4
// - Master user output words at a+10 to a+14
// - Reply words mirrored at a+20 to a+31
// - Command words mirrored at a+36 to a+47
// - Status bit5 touch done, bit0 display done
// - Status bit7 requests tag code readout
// - Status bit9 init done, bit11 ready
// - Status bit10 error, control bit10 clears
// - Init command code 1: 1 command, 2 ordinary
// - Ladder mode setting overrides offline mode
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.svh"

module fpc_panel_cmd (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register bus
	input wire fpc_pkg::fpc_axi_req_t axi_req,
	output var fpc_pkg::fpc_axi_rsp_t axi_rsp,
	// Words and bits from the master
	input wire fpc_pkg::fpc_word_t [15:0] cmd_write_word_base,
	input wire fpc_pkg::fpc_word_t ctrl_word,
	input wire fpc_pkg::fpc_word_t [4:0] ry_user,
	// Words and bits to the master
	output var fpc_pkg::fpc_word_t status_word,
	output var fpc_pkg::fpc_word_t [4:0] rx_user,
	output var fpc_pkg::fpc_word_t [15:0] reply_read_word_base
);
	import fpc_pkg::*;

	// ----------------------------------------------------------------
	// State and panel memory
	// ----------------------------------------------------------------
	fpc_state_t r;
	fpc_state_t n;
	// System area words 0..19 live here too; their meaning is owned by panel software
	fpc_word_t mem [`FPC_MEM_WORDS];
	logic wr_en;
	logic [10:0] wr_addr;
	fpc_word_t wr_data;
	logic bus_wr;
	logic per_act;
	logic per_hit;
	logic disp_rise;
	logic ok;
	logic [7:0] code;
	logic [7:0] cnt;
	logic [7:0] mon_lim;
	logic [7:0] per_lim;
	logic [10:0] woff;
	logic [10:0] bidx;
	logic [31:0] ctrl_w;
	logic [31:0] strb_mask;
	fpc_word_t old_word;
	fpc_mode_t eff_mode;

	assign axi_rsp = r.rsp;
	assign status_word = r.status;
	assign rx_user = r.rx_user;
	assign reply_read_word_base = r.reply;

	// ----------------------------------------------------------------
	// Panel memory view, link area resolved live
	// ----------------------------------------------------------------
	function automatic fpc_word_t rd_word(input logic [10:0] ad);
		logic [10:0] off;
		begin
			off = ad - r.cfg.link_a;
			rd_word = 16'h0000;
			if (16'(ad) > `FPC_ADDR_MAX) begin
				rd_word = 16'h0000;
			end else if (ad >= r.cfg.link_a && off < `FPC_LINK_LEN) begin
				if (off < `FPC_OFF_RX + `FPC_USER_WORDS) begin
					rd_word = r.rx_user[3'(off)];
				end else if (off == `FPC_OFF_STAT) begin
					rd_word = r.status;
				end else if (off >= `FPC_OFF_RY && off < `FPC_OFF_RY + `FPC_USER_WORDS) begin
					rd_word = ry_user[3'(off - `FPC_OFF_RY)];
				end else if (off == `FPC_OFF_CTRL) begin
					rd_word = ctrl_word;
				end else if (off >= `FPC_OFF_RWR && off < `FPC_OFF_RWR + `FPC_RW_WORDS) begin
					rd_word = r.reply[4'(off - `FPC_OFF_RWR)];
				end else if (off >= `FPC_OFF_RWW && off < `FPC_OFF_RWW + `FPC_RW_WORDS) begin
					rd_word = cmd_write_word_base[4'(off - `FPC_OFF_RWW)];
				end
			end else begin
				rd_word = mem[ad];
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		wr_en = 1'b0;
		wr_addr = 11'h000;
		wr_data = 16'h0000;
		ok = 1'b1;
		code = cmd_write_word_base[0][15:8];
		cnt = cmd_write_word_base[0][7:0];
		bidx = r.aw_addr[12:2];
		strb_mask = {{8{r.w_strb[3]}}, {8{r.w_strb[2]}}, {8{r.w_strb[1]}}, {8{r.w_strb[0]}}};
		old_word = rd_word(bidx);
		ctrl_w = (r.cfg & ~strb_mask) | (r.w_data & strb_mask);
		per_hit = 1'b0;
		n.ctrl_prev = ctrl_word;
		disp_rise = ctrl_word[`FPC_CT_DISP] && !r.ctrl_prev[`FPC_CT_DISP];
		// Ladder setting wins; offline choice only without one
		eff_mode = r.ladder_set ? r.mode : (r.cfg.off_ord ? FPC_MODE_ORD : FPC_MODE_CMD);
		case (r.cfg.nodes)
			3'h4: begin
				mon_lim = `FPC_MON_LIM4;
				per_lim = `FPC_PER_LIM4;
			end
			3'h2: begin
				mon_lim = `FPC_MON_LIM2;
				per_lim = `FPC_PER_LIM2;
			end
			default: begin
				mon_lim = `FPC_MON_LIM3;
				per_lim = `FPC_PER_LIM3;
			end
		endcase

		// Bus write channel: address and data taken in either order
		if (axi_req.awvalid && r.rsp.awready) begin
			n.aw_held = 1'b1;
			n.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && r.rsp.wready) begin
			n.w_held = 1'b1;
			n.w_data = axi_req.wdata;
			n.w_strb = axi_req.wstrb;
		end
		if (r.rsp.bvalid && axi_req.bready) begin
			n.rsp.bvalid = 1'b0;
		end
		bus_wr = r.aw_held && r.w_held;
		if (bus_wr) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = `FPC_RESP_OKAY;
			if (r.aw_addr < `FPC_MEM_END) begin
				if (16'(bidx) > `FPC_ADDR_MAX) begin
					n.rsp.bresp = `FPC_RESP_SLVERR;
				end else begin
					wr_en = 1'b1;
					wr_addr = bidx;
					wr_data = {r.w_strb[1] ? r.w_data[15:8] : old_word[15:8],
						r.w_strb[0] ? r.w_data[7:0] : old_word[7:0]};
				end
			end else if (r.aw_addr == `FPC_REG_CTRL) begin
				n.cfg = fpc_cfg_t'(ctrl_w);
				n.cfg.rsv_hi = 12'h000;
				n.cfg.rsv_mid = 2'h0;
				// Keeps the link area clear of the system area
				if (n.cfg.link_a < `FPC_LINK_MIN) begin
					n.cfg.link_a = `FPC_LINK_MIN;
				end
				if (n.cfg.nodes < 3'h2 || n.cfg.nodes > 3'h4) begin
					n.cfg.nodes = r.cfg.nodes;
				end
			end else if (r.aw_addr != `FPC_REG_STAT) begin
				n.rsp.bresp = `FPC_RESP_SLVERR;
			end
		end

		// Bus read channel, answered from the live view
		if (r.rsp.rvalid && axi_req.rready) begin
			n.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && r.rsp.arready) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rresp = `FPC_RESP_OKAY;
			n.rsp.rdata = 32'h0000_0000;
			if (axi_req.araddr < `FPC_MEM_END) begin
				if (16'(axi_req.araddr[12:2]) > `FPC_ADDR_MAX) begin
					n.rsp.rresp = `FPC_RESP_SLVERR;
				end else begin
					n.rsp.rdata = {16'h0000, rd_word(axi_req.araddr[12:2])};
				end
			end else if (axi_req.araddr == `FPC_REG_CTRL) begin
				n.rsp.rdata = r.cfg;
			end else if (axi_req.araddr == `FPC_REG_STAT) begin
				n.rsp.rdata = {r.mon_cnt, 1'b0, r.per_cnt, 4'h0, eff_mode, r.ladder_set,
					r.per_seen[0], r.status};
			end else begin
				n.rsp.rresp = `FPC_RESP_SLVERR;
			end
		end
		n.rsp.awready = !n.aw_held && !n.rsp.bvalid;
		n.rsp.wready = !n.w_held && !n.rsp.bvalid;
		n.rsp.arready = !n.rsp.rvalid;

		// Handshake flags drop with their requests
		n.disp_done = r.disp_done && ctrl_word[`FPC_CT_DISP];
		n.init_done = r.init_done && ctrl_word[`FPC_CT_INIT];
		if (ctrl_word[`FPC_CT_ERST] && !r.ctrl_prev[`FPC_CT_ERST]) begin
			n.err = 1'b0;
		end
		if (ctrl_word[`FPC_CT_INIT] && !r.ctrl_prev[`FPC_CT_INIT]) begin
			n.init_done = 1'b1;
		end

		// Command decode on the display request edge
		if (disp_rise) begin
			case (code)
				`FPC_CODE_INIT: begin
					if (cnt == `FPC_INIT_CMDMON || cnt == `FPC_INIT_ORDMON) begin
						n.ladder_set = 1'b1;
						n.mode = (cnt == `FPC_INIT_CMDMON) ? FPC_MODE_CMD : FPC_MODE_ORD;
					end else begin
						ok = 1'b0;
					end
				end
				`FPC_CODE_MON: begin
					ok = (cnt != 8'h00) && (cnt <= mon_lim);
					for (int k = 1; k < 15; k++) begin
						if (8'(k) <= cnt && cmd_write_word_base[k] > `FPC_ADDR_MAX) begin
							ok = 1'b0;
						end
					end
					if (ok) begin
						n.mon_cnt = cnt[3:0];
						n.mon_idx = 4'h0;
						for (int k = 0; k < 14; k++) begin
							n.mon_addr[k] = cmd_write_word_base[k + 1][10:0];
						end
					end
				end
				`FPC_CODE_PER: begin
					ok = (cnt != 8'h00) && (cnt <= per_lim);
					for (int k = 1; k < 8; k++) begin
						if (8'(k) <= cnt && cmd_write_word_base[k] > `FPC_ADDR_MAX) begin
							ok = 1'b0;
						end
					end
					if (ok) begin
						n.per_cnt = cnt[2:0];
						n.per_idx = 3'h0;
						n.per_seen = 7'h00;
						for (int k = 0; k < 7; k++) begin
							n.per_addr[k] = cmd_write_word_base[k + 1][10:0];
						end
					end
				end
				default: begin
					ok = 1'b1;
				end
			endcase
			n.disp_done = ok;
			if (!ok) begin
				n.err = 1'b1;
			end
		end

		// Command monitor: one registered address refreshed per cycle
		if (eff_mode == FPC_MODE_CMD && ctrl_word[`FPC_CT_MON] && r.mon_cnt != 4'h0) begin
			n.reply[r.mon_idx] = rd_word(r.mon_addr[r.mon_idx]);
			n.mon_idx = (r.mon_idx + 4'h1 >= r.mon_cnt) ? 4'h0 : r.mon_idx + 4'h1;
		end

		// Periodic write: yields the single write port to the bus for one cycle.
		// Release of the request forgets the shadows, so the next request rewrites all.
		per_act = ctrl_word[`FPC_CT_PER] && r.per_cnt != 3'h0 && !bus_wr;
		if (!ctrl_word[`FPC_CT_PER]) begin
			n.per_seen = 7'h00;
		end
		if (per_act) begin
			per_hit = !r.per_seen[r.per_idx] ||
				cmd_write_word_base[r.per_idx] != r.per_shadow[r.per_idx];
			if (per_hit) begin
				wr_en = 1'b1;
				wr_addr = r.per_addr[r.per_idx];
				wr_data = cmd_write_word_base[r.per_idx];
				n.per_shadow[r.per_idx] = cmd_write_word_base[r.per_idx];
				n.per_seen[r.per_idx] = 1'b1;
			end
			n.per_idx = (r.per_idx + 3'h1 >= r.per_cnt) ? 3'h0 : r.per_idx + 3'h1;
		end

		// Writes landing in the link area reach only the panel-owned words
		woff = wr_addr - r.cfg.link_a;
		if (wr_en && wr_addr >= r.cfg.link_a && woff < `FPC_LINK_LEN) begin
			if (woff < `FPC_OFF_RX + `FPC_USER_WORDS) begin
				n.rx_user[3'(woff)] = wr_data;
			end else if (woff >= `FPC_OFF_RWR && woff < `FPC_OFF_RWR + `FPC_RW_WORDS &&
				eff_mode == FPC_MODE_ORD) begin
				n.reply[4'(woff - `FPC_OFF_RWR)] = wr_data;
			end
		end

		// Status word to the master
		n.status = 16'h0000;
		n.status[`FPC_ST_DISP] = n.disp_done;
		n.status[`FPC_ST_TOUCH] = n.cfg.touch_done;
		n.status[`FPC_ST_TAG] = n.cfg.tag_req;
		n.status[`FPC_ST_INIT] = n.init_done;
		n.status[`FPC_ST_ERR] = n.err;
		n.status[`FPC_ST_RDY] = n.cfg.ready;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r <= '0;
			r.cfg <= fpc_cfg_t'(`FPC_CTRL_RST);
			r.mode <= FPC_MODE_ORD;
		end else begin
			r <= n;
		end
	end

	// Link-area words never enter the array, so the mirrors stay single-sourced
	always_ff @(posedge sys_clk) begin
		if (wr_en && !(wr_addr >= r.cfg.link_a && woff < `FPC_LINK_LEN)) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_mon_count_lim: assert property (
		disp_rise && code == `FPC_CODE_MON && cnt > mon_lim |=> r.err && !status_word[0]
	) else $error("monitor count above limit accepted");
	a_mon_addr_rng: assert property (
		disp_rise && code == `FPC_CODE_MON && cnt == 8'h01 && cmd_write_word_base[1] > 16'd2031
		|=> r.err && r.mon_cnt == $past(r.mon_cnt)
	) else $error("monitor address out of range accepted");
	a_per_count_lim: assert property (
		disp_rise && code == `FPC_CODE_PER && cnt > per_lim |=> r.err && status_word[10]
	) else $error("periodic count above limit accepted");
	a_per_store: assert property (
		disp_rise && code == `FPC_CODE_PER && cnt == 8'h01 && cmd_write_word_base[1] < 16'd2032
		|=> r.per_cnt == 3'h1 && r.per_addr[0] == $past(cmd_write_word_base[1][10:0])
	) else $error("periodic address not registered");
	a_per_rewrite: assert property (
		per_act && per_hit |-> wr_en && wr_addr == r.per_addr[r.per_idx]
	) else $error("changed periodic word not written");
	a_link_floor: assert property (
		r.cfg.link_a >= 11'd20
	) else $error("link start below system area");
	a_err_clear: assert property (
		$rose(ctrl_word[10]) && !disp_rise |=> !r.err && !status_word[10]
	) else $error("error reset ignored");
	a_ladder_prio: assert property (
		disp_rise && cmd_write_word_base[0] == 16'h0102 |=> r.ladder_set && eff_mode == FPC_MODE_ORD
	) else $error("ladder mode setting not taken");
	a_status_map: assert property (
		$rose(ctrl_word[9]) |=> status_word[9] && status_word[11] == r.cfg.ready
	) else $error("init complete flag not raised");

	c_mon_accept: cover property (disp_rise && code == `FPC_CODE_MON ##1 status_word[0]);
	c_per_write: cover property (per_act && per_hit ##1 per_act && per_hit);
	c_err_cycle: cover property (r.err ##[1:20] !r.err);
endmodule
`default_nettype wire

// >>> verilog/fpc_pkg.sv
// Types of the panel command map: bus carriers, configuration, mode, state.
// Assumes fpc_defines.svh on the include path.
package fpc_pkg;
	`include "fpc_defines.svh"

	typedef logic [15:0] fpc_word_t;

	typedef enum logic [1:0] {
		FPC_MODE_CMD = 2'b01,
		FPC_MODE_ORD = 2'b10
	} fpc_mode_t;

	typedef struct packed {
		logic [11:0] rsv_hi;
		logic ready;
		logic tag_req;
		logic touch_done;
		logic off_ord;
		logic [1:0] rsv_mid;
		logic [2:0] nodes;
		logic [10:0] link_a;
	} fpc_cfg_t;

	typedef struct packed {
		logic [13:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [13:0] araddr;
		logic arvalid;
		logic rready;
	} fpc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fpc_axi_rsp_t;

	typedef struct packed {
		fpc_cfg_t cfg;
		fpc_mode_t mode;
		logic ladder_set;
		logic disp_done;
		logic err;
		logic init_done;
		logic [15:0] ctrl_prev;
		logic [3:0] mon_cnt;
		logic [3:0] mon_idx;
		logic [13:0][10:0] mon_addr;
		logic [2:0] per_cnt;
		logic [2:0] per_idx;
		logic [6:0][10:0] per_addr;
		fpc_word_t [6:0] per_shadow;
		logic [6:0] per_seen;
		fpc_word_t [4:0] rx_user;
		fpc_word_t [15:0] reply;
		fpc_word_t status;
		logic aw_held;
		logic [13:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		fpc_axi_rsp_t rsp;
	} fpc_state_t;
endpackage
